// ### logic/adfc_feed_ctrl.sv
// dc feed state decode, adaptive linefeed and loop closure detection with apb registers
`timescale 1ns/1ps
`include "adfc_params.svh"

// Contract
// - state 101 keeps feed active, audio off until off-hook detected.
// - active state with on-hook loop enters reduced-power standby.
// - state 110 gives reverse polarity on-hook transmission, data path usable.
// - state 111 sets ring lead high impedance, tip lead driven.
// - current limit is 5 bits, 18 mA at 0 to 45 mA at 1f.
// - feed uses both headrooms, open voltage, thresholds, boost, current limit.
// - integrated stage: 640 ohm before transition, 320 ohm after.
// - discrete stage: 320 ohm before and after transition.
// - falling voltage at lower threshold: 320 ohm and add boost.
// - after transition keep 320 ohm until current limit, then constant current.
// - loop opening leaves constant current back to 320 ohm region.
// - rising voltage at upper threshold restores impedance, removes boost.
// - zero boost removes boost but impedance still switches.
// - loop closure uses on/off thresholds, current filter, debounce settings.
// - debounced loop closure sets loop_closure_flag in status.
// - reset line state is open, all drive high impedance.
// - codes 001..100 select forward active, forward oht, tip open, ringing.
// - low battery: tracked voltage is battery minus headroom sum.
module adfc_feed_ctrl
    import adfc_pkg::*;
#(
    parameter int SAMPLE_CYC = `ADFC_SAMPLE_CYC,
    parameter bit DISCRETE   = 1'b0
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] vloop_meas,
    input  wire logic [15:0] iloop_meas,
    input  wire logic [15:0] vbat_meas,
    output adfc_feed_t       feed,
    output logic             const_current,
    output logic             battery_rail_select
);
    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    // the tick counter is 16 bits wide, so longer sample periods cannot be served
    if (SAMPLE_CYC < 2 || SAMPLE_CYC > 65535) begin : g_bad_sample
        $error("sample period out of range");
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [2:0]  line_state_code_reg;
    logic [2:0]  line_state_shadow_reg;
    logic [7:0]  relay_battery_ctrl_reg;
    logic [4:0]  loop_current_limit_reg;
    logic [14:0] open_voltage_reg;
    logic [14:0] common_headroom_reg;
    logic [14:0] boost_reg;
    logic [15:0] lower_th_reg;
    logic [15:0] upper_th_reg;
    logic [14:0] battery_headroom_reg;
    logic [14:0] ringing_headroom_reg;
    logic [15:0] tracked_open_voltage_reg;
    logic [15:0] offhk_th_reg;
    logic [15:0] onhk_th_reg;
    logic [3:0]  lpf_shift_reg;
    logic [15:0] dbi_reg;
    logic        loop_closure_flag_reg;
    logic        offhook_reg;
    logic        low_z_region_reg;

    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic        sample_tick;
    logic [15:0] tick_cnt_reg;

    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pslverr = psel && penable && !addr_ok;
    assign battery_rail_select = relay_battery_ctrl_reg[0];

    function automatic logic decode_ok(input logic [11:0] a);
        decode_ok = (a[1:0] == 2'h0) && (a <= `ADFC_OFF_FEED);
    endfunction
    assign addr_ok = decode_ok(paddr);

    // ----------------------------------------------------------------
    // register writes; line state defaults to open
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_state_code_reg    <= `ADFC_RST_LINE_STATE;
            relay_battery_ctrl_reg <= 8'h00;
            loop_current_limit_reg <= `ADFC_RST_LOOP_CURRENT_LIMIT;
            open_voltage_reg       <= `ADFC_RST_V15;
            common_headroom_reg    <= `ADFC_RST_V15;
            boost_reg              <= `ADFC_RST_V15;
            lower_th_reg           <= `ADFC_RST_V16;
            upper_th_reg           <= `ADFC_RST_V16;
            battery_headroom_reg   <= `ADFC_RST_V15;
            ringing_headroom_reg   <= `ADFC_RST_V15;
            offhk_th_reg           <= `ADFC_RST_V16;
            onhk_th_reg            <= `ADFC_RST_V16;
            lpf_shift_reg          <= `ADFC_RST_LPF;
            dbi_reg                <= `ADFC_RST_DBI;
        end else if (wr_en && addr_ok) begin
            case (paddr)
                `ADFC_OFF_LINE_STATE: line_state_code_reg <= pwdata[2:0];
                `ADFC_OFF_RELAY:      relay_battery_ctrl_reg <= pwdata[7:0];
                `ADFC_OFF_LOOP_CURRENT_LIMIT:       loop_current_limit_reg <= pwdata[4:0];
                `ADFC_OFF_VOC:        open_voltage_reg <= pwdata[14:0];
                `ADFC_OFF_VCM:        common_headroom_reg <= pwdata[14:0];
                `ADFC_OFF_BOOST:      boost_reg <= pwdata[14:0];
                `ADFC_OFF_LTH:        lower_th_reg <= pwdata[15:0];
                `ADFC_OFF_HTH:        upper_th_reg <= pwdata[15:0];
                `ADFC_OFF_VOV:        battery_headroom_reg <= pwdata[14:0];
                `ADFC_OFF_RINGING_HEADROOM:    ringing_headroom_reg <= pwdata[14:0];
                `ADFC_OFF_OFFHK_TH:   offhk_th_reg <= pwdata[15:0];
                `ADFC_OFF_ONHK_TH:    onhk_th_reg <= pwdata[15:0];
                `ADFC_OFF_LPF:        lpf_shift_reg <= pwdata[3:0];
                `ADFC_OFF_DBI:        dbi_reg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                `ADFC_OFF_LINE_STATE: prdata = {25'h0, line_state_shadow_reg, 1'b0,
                                                line_state_code_reg};
                `ADFC_OFF_RELAY:      prdata = {24'h0, relay_battery_ctrl_reg};
                `ADFC_OFF_LOOP_CURRENT_LIMIT:       prdata = {27'h0, loop_current_limit_reg};
                `ADFC_OFF_VOC:        prdata = {17'h0, open_voltage_reg};
                `ADFC_OFF_VCM:        prdata = {17'h0, common_headroom_reg};
                `ADFC_OFF_BOOST:      prdata = {17'h0, boost_reg};
                `ADFC_OFF_LTH:        prdata = {16'h0, lower_th_reg};
                `ADFC_OFF_HTH:        prdata = {16'h0, upper_th_reg};
                `ADFC_OFF_VOV:        prdata = {17'h0, battery_headroom_reg};
                `ADFC_OFF_RINGING_HEADROOM:    prdata = {17'h0, ringing_headroom_reg};
                `ADFC_OFF_TRACK:      prdata = {16'h0, tracked_open_voltage_reg};
                `ADFC_OFF_OFFHK_TH:   prdata = {16'h0, offhk_th_reg};
                `ADFC_OFF_ONHK_TH:    prdata = {16'h0, onhk_th_reg};
                `ADFC_OFF_LPF:        prdata = {28'h0, lpf_shift_reg};
                `ADFC_OFF_DBI:        prdata = {16'h0, dbi_reg};
                `ADFC_OFF_STATUS:     prdata = {30'h0, offhook_reg, loop_closure_flag_reg};
                `ADFC_OFF_FEED:       prdata = {15'h0, const_current, low_z_region_reg,
                                                feed.src_impedance_ohm[9:0], 5'h0};
                default:              prdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // monitor sample enable (800 Hz)
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tick_cnt_reg <= 16'h0000;
        else if (sample_tick)
            tick_cnt_reg <= 16'h0000;
        else
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
    assign sample_tick = (tick_cnt_reg == 16'(SAMPLE_CYC - 1));

    // ----------------------------------------------------------------
    // tracked open voltage; saturating so a short battery never wraps
    // ----------------------------------------------------------------
    logic [16:0] headroom_sum;
    logic [16:0] need_sum;
    assign headroom_sum = {2'b00, battery_headroom_reg} + {2'b00, common_headroom_reg};
    assign need_sum     = headroom_sum + {2'b00, open_voltage_reg};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tracked_open_voltage_reg <= `ADFC_RST_V16;
        else if (sample_tick) begin
            if ({1'b0, vbat_meas} >= need_sum)
                tracked_open_voltage_reg <= {1'b0, open_voltage_reg};
            else if ({1'b0, vbat_meas} > headroom_sum)
                tracked_open_voltage_reg <= 16'({1'b0, vbat_meas} - headroom_sum);
            else
                tracked_open_voltage_reg <= 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // adaptive region with hysteresis; thresholds are signed offsets
    // ----------------------------------------------------------------
    logic signed [17:0] low_trip;
    logic signed [17:0] high_trip;
    logic signed [17:0] vloop_s;
    assign low_trip  = $signed({2'b00, tracked_open_voltage_reg})
                       + $signed({{2{lower_th_reg[15]}}, lower_th_reg});
    assign high_trip = $signed({2'b00, tracked_open_voltage_reg})
                       + $signed({{2{upper_th_reg[15]}}, upper_th_reg});
    assign vloop_s   = $signed({2'b00, vloop_meas});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            low_z_region_reg <= 1'b0;
        else if (sample_tick) begin
            if (!low_z_region_reg && vloop_s <= low_trip)
                low_z_region_reg <= 1'b1;
            else if (low_z_region_reg && vloop_s >= high_trip)
                low_z_region_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // loop current filter and debounced closure detection
    // ----------------------------------------------------------------
    logic [15:0] ifilt_reg;
    logic [15:0] dbi_cnt_reg;
    logic        raw_closed;
    logic [16:0] ifilt_step;
    assign ifilt_step = ({1'b0, iloop_meas} >= {1'b0, ifilt_reg})
                      ? 17'(({1'b0, iloop_meas} - {1'b0, ifilt_reg}) >> lpf_shift_reg)
                      : 17'(({1'b0, ifilt_reg} - {1'b0, iloop_meas}) >> lpf_shift_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ifilt_reg <= 16'h0000;
        else if (sample_tick) begin
            if (iloop_meas >= ifilt_reg)
                ifilt_reg <= ifilt_reg + ifilt_step[15:0];
            else
                ifilt_reg <= ifilt_reg - ifilt_step[15:0];
        end
    end

    // off-hook and on-hook thresholds differ, so the raw state has its own hysteresis
    assign raw_closed = offhook_reg ? (ifilt_reg > onhk_th_reg) : (ifilt_reg >= offhk_th_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbi_cnt_reg <= 16'h0000;
            offhook_reg <= 1'b0;
        end else if (sample_tick) begin
            if (raw_closed == offhook_reg)
                dbi_cnt_reg <= 16'h0000;
            else if (dbi_cnt_reg >= dbi_reg) begin
                dbi_cnt_reg <= 16'h0000;
                offhook_reg <= raw_closed;
            end else
                dbi_cnt_reg <= dbi_cnt_reg + 16'h0001;
        end
    end

    // sticky flag, write one to clear; a new closure in the clear cycle wins
    logic closure_event;
    assign closure_event = sample_tick && (raw_closed != offhook_reg) && raw_closed
                           && (dbi_cnt_reg >= dbi_reg);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            loop_closure_flag_reg <= 1'b0;
        else if (closure_event)
            loop_closure_flag_reg <= 1'b1;
        else if (wr_en && paddr == `ADFC_OFF_STATUS && pwdata[`ADFC_ST_LCR_BIT])
            loop_closure_flag_reg <= 1'b0;
    end

    // ----------------------------------------------------------------
    // shadow of the state in effect, updated on the sample clock
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            line_state_shadow_reg <= `ADFC_RST_LINE_STATE;
        else if (sample_tick)
            line_state_shadow_reg <= line_state_code_reg;
    end

    // ----------------------------------------------------------------
    // state decode and feed output
    // ----------------------------------------------------------------
    adfc_line_state_t ls;
    logic [16:0] boosted;
    assign ls = adfc_line_state_t'(line_state_shadow_reg);
    assign boosted = {1'b0, tracked_open_voltage_reg} + {2'b00, boost_reg};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            const_current <= 1'b0;
        else if (!low_z_region_reg || !offhook_reg)
            const_current <= 1'b0;
        else
            const_current <= (ifilt_reg >= {11'h000, loop_current_limit_reg});
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            feed <= '0;
        else begin
            feed.tip_drive_en  <= !(ls == ADFC_LS_OPEN || ls == ADFC_LS_TIP_OPEN);
            feed.ring_drive_en <= !(ls == ADFC_LS_OPEN || ls == ADFC_LS_RING_OPEN);
            feed.reverse_pol   <= (ls == ADFC_LS_REV_ACT || ls == ADFC_LS_REV_OHT) ||
                                  (ls == ADFC_LS_RING_OPEN);
            feed.audio_powered <= ((ls == ADFC_LS_FWD_ACT || ls == ADFC_LS_REV_ACT)
                                   && offhook_reg)
                                  || ls == ADFC_LS_FWD_OHT || ls == ADFC_LS_REV_OHT;
            feed.standby_low_power <= (ls == ADFC_LS_FWD_ACT || ls == ADFC_LS_REV_ACT)
                                      && !offhook_reg;
            feed.ringing_en    <= (ls == ADFC_LS_RINGING);
            feed.high_z_src    <= (ls == ADFC_LS_OPEN);
            feed.src_impedance_ohm <= (DISCRETE || low_z_region_reg)
                                      ? `ADFC_Z_LOW_OHM : `ADFC_Z_HIGH_OHM;
            feed.feed_voltage  <= low_z_region_reg ? boosted[15:0]
                                  : tracked_open_voltage_reg;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_OPEN_HIGHZ: assert property (
        ls == ADFC_LS_OPEN |=> !feed.tip_drive_en && !feed.ring_drive_en)
        else $error("open state drives a lead");
    AST_RING_OPEN: assert property (
        ls == ADFC_LS_RING_OPEN |=> feed.tip_drive_en && !feed.ring_drive_en)
        else $error("ring open decode wrong");
    AST_TIP_OPEN: assert property (
        ls == ADFC_LS_TIP_OPEN |=> !feed.tip_drive_en && feed.ring_drive_en)
        else $error("tip open decode wrong");
    AST_RINGING: assert property (
        ls == ADFC_LS_RINGING |=> feed.ringing_en && !feed.audio_powered)
        else $error("ringing decode wrong");
    AST_REV_OHT: assert property (
        ls == ADFC_LS_REV_OHT |=> feed.reverse_pol && feed.audio_powered)
        else $error("reverse oht decode wrong");
    AST_REV_ACT_AUDIO: assert property (
        ls == ADFC_LS_REV_ACT && !offhook_reg |=> !feed.audio_powered)
        else $error("audio powered while on-hook");
    AST_STANDBY: assert property (
        (ls == ADFC_LS_FWD_ACT || ls == ADFC_LS_REV_ACT) && !offhook_reg |=> feed.standby_low_power)
        else $error("no standby on-hook");
    AST_LOW_Z: assert property (
        $rose(low_z_region_reg) |=> feed.src_impedance_ohm == `ADFC_Z_LOW_OHM)
        else $error("impedance not 320 after transition");
    AST_HIGH_Z: assert property (
        $fell(low_z_region_reg) && !DISCRETE |=> feed.src_impedance_ohm == `ADFC_Z_HIGH_OHM)
        else $error("impedance not restored");
    AST_DISCRETE_Z: assert property (
        DISCRETE && feed.ring_drive_en |-> feed.src_impedance_ohm == `ADFC_Z_LOW_OHM)
        else $error("discrete stage not at 320");
    AST_REGION_ON_TICK: assert property (!sample_tick |=> $stable(low_z_region_reg))
        else $error("region changed off sample");
    AST_FLAG_SET: assert property (closure_event |=> loop_closure_flag_reg)
        else $error("closure flag not set");
    AST_FLAG_CLEAR: assert property (
        wr_en && paddr == `ADFC_OFF_STATUS && pwdata[`ADFC_ST_LCR_BIT] && !closure_event
        |=> !loop_closure_flag_reg)
        else $error("closure flag not cleared");
    AST_CC_REGION: assert property (!low_z_region_reg |=> !const_current)
        else $error("constant current outside low z region");

    COV_OFFHOOK: cover property ($rose(offhook_reg));
    COV_TRANSITION: cover property ($rose(low_z_region_reg));
    COV_CC: cover property ($rose(const_current));
    COV_RETURN: cover property ($fell(low_z_region_reg));
endmodule

// ### logic/adfc_params.svh
// register offsets, field positions, reset values and timing counts for the dc feed control
`ifndef ADFC_PARAMS_SVH
`define ADFC_PARAMS_SVH
`define ADFC_OFF_LINE_STATE   12'h000
`define ADFC_OFF_RELAY        12'h004
`define ADFC_OFF_LOOP_CURRENT_LIMIT         12'h008
`define ADFC_OFF_VOC          12'h00c
`define ADFC_OFF_VCM          12'h010
`define ADFC_OFF_BOOST        12'h014
`define ADFC_OFF_LTH          12'h018
`define ADFC_OFF_HTH          12'h01c
`define ADFC_OFF_VOV          12'h020
`define ADFC_OFF_RINGING_HEADROOM      12'h024
`define ADFC_OFF_TRACK        12'h028
`define ADFC_OFF_OFFHK_TH     12'h02c
`define ADFC_OFF_ONHK_TH      12'h030
`define ADFC_OFF_LPF          12'h034
`define ADFC_OFF_DBI          12'h038
`define ADFC_OFF_STATUS       12'h03c
`define ADFC_OFF_FEED         12'h040
`define ADFC_LS_CODE_LSB      0
`define ADFC_LS_SHADOW_LSB    4
`define ADFC_ST_LCR_BIT       0
`define ADFC_ST_OFFHK_BIT     1
`define ADFC_RST_LINE_STATE   3'h0
`define ADFC_RST_LOOP_CURRENT_LIMIT         5'h00
`define ADFC_RST_V15          15'h0000
`define ADFC_RST_V16          16'h0000
`define ADFC_RST_DBI          16'h0010
`define ADFC_RST_LPF          4'h2
`define ADFC_SAMPLE_HZ        800
`define ADFC_CLK_HZ           10000000
`define ADFC_SAMPLE_CYC       (`ADFC_CLK_HZ / `ADFC_SAMPLE_HZ)
`define ADFC_Z_HIGH_OHM       10'h280
`define ADFC_Z_LOW_OHM        10'h140
`endif

// ### logic/adfc_pkg.sv
// types shared by the dc feed control block
package adfc_pkg;
    typedef enum logic [2:0] {
        ADFC_LS_OPEN      = 3'h0,
        ADFC_LS_FWD_ACT   = 3'h1,
        ADFC_LS_FWD_OHT   = 3'h2,
        ADFC_LS_TIP_OPEN  = 3'h3,
        ADFC_LS_RINGING   = 3'h4,
        ADFC_LS_REV_ACT   = 3'h5,
        ADFC_LS_REV_OHT   = 3'h6,
        ADFC_LS_RING_OPEN = 3'h7
    } adfc_line_state_t;

    typedef struct packed {
        logic       tip_drive_en;
        logic       ring_drive_en;
        logic       reverse_pol;
        logic       audio_powered;
        logic       standby_low_power;
        logic       ringing_en;
        logic       high_z_src;
        logic [9:0] src_impedance_ohm;
        logic [15:0] feed_voltage;
    } adfc_feed_t;
endpackage

// ### tb/adfc_loop_model.sv
// subscriber loop seen through the linefeed stage: voltage, current and battery
`timescale 1ns/1ps
module adfc_loop_model
    import adfc_pkg::*;
(
    input  wire logic        offhook,
    input  wire logic [15:0] vbat_set,
    input  adfc_feed_t       feed,
    output logic      [15:0] vloop_meas,
    output logic      [15:0] iloop_meas,
    output logic      [15:0] vbat_meas
);
    // a load only draws current while at least one lead is driven
    logic drawn;
    assign drawn      = offhook & (feed.tip_drive_en | feed.ring_drive_en);
    assign vloop_meas = drawn ? 16'h1000 : 16'h2800;
    assign iloop_meas = drawn ? 16'h0020 : 16'h0000;
    assign vbat_meas  = vbat_set;
endmodule

// ### tb/tb_adaptive_dc_feed_state_control.sv
// register tasks and scenarios for the dc feed control
`timescale 1ns/1ps
`include "adfc_params.svh"
module tb_adaptive_dc_feed_state_control;
    import adfc_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] vloop, iloop, vbat;
    logic        offhook = 1'b0;
    logic [15:0] vbat_set = 16'h4000;
    adfc_feed_t  feed;
    adfc_feed_t  feed_d;
    logic        cc, rail;
    logic [31:0] rd;
    logic        err;
    int          err_total = 0;
    int          compares = 0;
    always #50 pclk = ~pclk;
    adfc_feed_ctrl #(.SAMPLE_CYC(8), .DISCRETE(1'b0)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .vloop_meas(vloop),
        .iloop_meas(iloop), .vbat_meas(vbat), .feed(feed), .const_current(cc),
        .battery_rail_select(rail));
    adfc_loop_model loop_i (.offhook(offhook), .vbat_set(vbat_set), .feed(feed),
        .vloop_meas(vloop), .iloop_meas(iloop), .vbat_meas(vbat));
    // discrete-stage twin sees the same bus and loop, only its impedance is compared
    adfc_feed_ctrl #(.SAMPLE_CYC(8), .DISCRETE(1'b1)) DUT_DISC (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(), .pready(), .pslverr(), .vloop_meas(vloop), .iloop_meas(iloop),
        .vbat_meas(vbat), .feed(feed_d), .const_current(), .battery_rail_select());
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_total++;
            close_out();
        end
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        #1;
    endtask
    task automatic wcyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    initial begin
        int i;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        #1 chk({feed.tip_drive_en, feed.ring_drive_en}, 0);
        apb(0, `ADFC_OFF_LINE_STATE, 0); chk(rd, 0);
        apb(0, `ADFC_OFF_DBI, 0); chk(rd, 32'h10);
        apb(0, `ADFC_OFF_LPF, 0); chk(rd, 32'h2);
        apb(0, 12'h100, 0); chk(rd, 0); chk({31'h0, err}, 1);
        apb(1, `ADFC_OFF_LOOP_CURRENT_LIMIT, 32'hff); apb(0, `ADFC_OFF_LOOP_CURRENT_LIMIT, 0); chk(rd, 32'h1f);
        $display("test registers done");
        // feed voltages pre-encoded by software as integer codes
        // 40 v open circuit, 5 v for headrooms and boost, -5 v and +5 v thresholds
        apb(1, `ADFC_OFF_VOC, 32'h2000); apb(1, `ADFC_OFF_VCM, 32'h0400);
        apb(1, `ADFC_OFF_VOV, 32'h0400); apb(1, `ADFC_OFF_BOOST, 32'h0400);
        apb(1, `ADFC_OFF_LTH, 32'hfc00); apb(1, `ADFC_OFF_HTH, 32'h0400);
        apb(1, `ADFC_OFF_LPF, 0); apb(1, `ADFC_OFF_DBI, 2);
        apb(1, `ADFC_OFF_OFFHK_TH, 32'h10); apb(1, `ADFC_OFF_ONHK_TH, 32'h08);
        apb(0, `ADFC_OFF_TRACK, 0); chk(rd, 32'h2000);
        for (i = 0; i < 8; i++) begin
            apb(1, `ADFC_OFF_LINE_STATE, i);
            wcyc(20);
            apb(0, `ADFC_OFF_LINE_STATE, 0); chk(rd[6:4], i);
            case (i)
                0: chk({feed.tip_drive_en, feed.ring_drive_en, feed.high_z_src}, 1);
                2: chk({feed.reverse_pol, feed.audio_powered}, 1);
                1: chk({feed.reverse_pol, feed.audio_powered, feed.standby_low_power}, 1);
                3: chk({feed.tip_drive_en, feed.ring_drive_en}, 1);
                4: chk(feed.ringing_en, 1);
                5: chk({feed.reverse_pol, feed.audio_powered, feed.standby_low_power}, 5);
                6: chk(feed.reverse_pol, 1);
                7: chk({feed.tip_drive_en, feed.ring_drive_en}, 2);
                default: ;
            endcase
        end
        $display("test states done");
        apb(1, `ADFC_OFF_LINE_STATE, 5);
        wcyc(20);
        chk({feed.src_impedance_ohm, feed.feed_voltage}, {10'h280, 16'h2000});
        chk(feed_d.src_impedance_ohm, 10'h140);
        offhook <= 1'b1;
        wcyc(40);
        chk({feed.src_impedance_ohm, feed.feed_voltage}, {10'h140, 16'h2400});
        chk({cc, feed.audio_powered, feed.standby_low_power}, 3'b110);
        i = 0;
        do begin
            apb(0, `ADFC_OFF_STATUS, 0);
            i++;
        end while (rd[0] !== 1'b1 && i < 60);
        if (rd[0] !== 1'b1) begin
            err_total++;
            close_out();
        end
        chk(rd[0], 1);
        apb(1, `ADFC_OFF_STATUS, 1); apb(0, `ADFC_OFF_STATUS, 0); chk(rd[1:0], 2'b10);
        offhook <= 1'b0;
        wcyc(40);
        chk({feed.src_impedance_ohm, feed.feed_voltage}, {10'h280, 16'h2000});
        chk(cc, 0);
        $display("test adaptive done");
        apb(1, `ADFC_OFF_BOOST, 0);
        offhook <= 1'b1;
        wcyc(40);
        chk({feed.src_impedance_ohm, feed.feed_voltage}, {10'h140, 16'h2000});
        offhook <= 1'b0;
        vbat_set <= 16'h2400;
        wcyc(40);
        apb(0, `ADFC_OFF_TRACK, 0); chk(rd, 32'h1c00);
        apb(1, `ADFC_OFF_RELAY, 1); #1 chk(rail, 1);
        $display("test zero boost and tracking done");
        close_out();
    end
    initial begin
        #3000000;
        err_total++;
        close_out();
    end
endmodule
